// ---- src/dbuc_consts.svh ----
// Constants of the analog output bank update controller: offsets, bits, resets, timing
`ifndef DBUC_CONSTS_SVH
`define DBUC_CONSTS_SVH

// ****************************************************************************
// Channel bank
// ****************************************************************************
`define DBUC_NUM_CH       16
`define DBUC_CODE_W       12
`define DBUC_IDX_W        4
`define DBUC_CODE_RST     12'h000

// ****************************************************************************
// Timing
// ****************************************************************************
`define DBUC_CLK_HZ       40000000
`define DBUC_OSC_HZ       1000000
`define DBUC_OSC_DIV      (`DBUC_CLK_HZ / `DBUC_OSC_HZ)
`define DBUC_PRE_W        6
`define DBUC_CNT_W        16

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define DBUC_ADR_CH_BASE  8'h00
`define DBUC_ADR_CMD_BASE 8'h40
`define DBUC_ADR_CNT0     8'h80
`define DBUC_ADR_CNT1     8'h84
`define DBUC_ADR_CNT2     8'h88
`define DBUC_ADR_CTRL     8'h8c
`define DBUC_ADR_STAT     8'h90
`define DBUC_ADR_MASK     8'h94
`define DBUC_ADR_STATE    8'h98

// ****************************************************************************
// Command indices inside the command window (read to trigger)
// ****************************************************************************
`define DBUC_CMD_SIMUL    4'h0
`define DBUC_CMD_INDIV    4'h1
`define DBUC_CMD_UPDATE   4'h2
`define DBUC_CMD_INT_ON   4'h3
`define DBUC_CMD_INT_OFF  4'h4
`define DBUC_CMD_UPD_ON   4'h5
`define DBUC_CMD_UPD_OFF  4'h6
`define DBUC_CMD_REF_FULL 4'h7
`define DBUC_CMD_REF_LOW  4'h8

// ****************************************************************************
// Field positions and reset values
// ****************************************************************************
`define DBUC_IRQ_W        2
`define DBUC_IRQ_TICK     0
`define DBUC_IRQ_EVT      1
`define DBUC_CTRL_EVT_EN  0
`define DBUC_CTRL_CASC_EN 1
`define DBUC_CTRL_RST     2'h0
`define DBUC_MASK_RST     2'h0
`define DBUC_ST_SIMUL     0
`define DBUC_ST_REF_LOW   1
`define DBUC_ST_UPD_EN    2
`define DBUC_ST_INT_EN    3

`endif

// ---- src/dbuc_pkg.sv ----
// Types shared by the analog output bank update controller
package dbuc_pkg;

	// Bus slave sequencing, Gray along idle -> wait -> ack
	typedef enum logic [1:0] {
		DBUC_BUS_IDLE = 2'b00,
		DBUC_BUS_WAIT = 2'b01,
		DBUC_BUS_ACK  = 2'b11
	} dbuc_bus_e;

	typedef logic [11:0] dbuc_code_t;
	typedef logic [15:0] dbuc_count_t;

endpackage : dbuc_pkg

// ---- src/dbuc_down_counter.sv ----
// One 16-bit programmable down counter with reload and terminal pulse
`timescale 1ns/1ps
`include "dbuc_consts.svh"

module dbuc_down_counter
	import dbuc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Programming
	input  wire logic        load_i,
	input  wire dbuc_count_t load_val_i,
	// Counting
	input  wire logic        count_en_i,
	output dbuc_count_t      count_o,
	output logic             term_o
);

	dbuc_count_t count_reg;
	dbuc_count_t count_next;
	dbuc_count_t reload_reg;
	logic        term_reg;
	wire logic   hit;

	// A reload of zero gives the full 65536 period
	assign hit        = (count_reg == 16'h0001);
	assign count_next = load_i ? load_val_i :
	                    count_en_i ? (hit ? reload_reg : count_reg - 16'h0001) : count_reg;

	// Count state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg  <= 16'h0000;
			reload_reg <= 16'h0000;
			term_reg   <= 1'b0;
		end else begin
			count_reg  <= count_next;
			reload_reg <= load_i ? load_val_i : reload_reg;
			term_reg   <= count_en_i & hit & ~load_i;
		end
	end

	assign count_o = count_reg;
	assign term_o  = term_reg;

endmodule // dbuc_down_counter

// ---- src/dbuc_code_mem.sv ----
// Two-rank code store: byte-loaded holding rank and word-moved output rank
`timescale 1ns/1ps
`include "dbuc_consts.svh"

module dbuc_code_mem
	import dbuc_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Holding rank writes
	input  wire logic                     wr_lo_i,
	input  wire logic                     wr_hi_i,
	input  wire logic [3:0]               wr_idx_i,
	input  wire dbuc_code_t               wr_data_i,
	// Transfers into the output rank
	input  wire logic                     xfer_one_i,
	input  wire logic                     xfer_all_i,
	// Readback and outputs
	input  wire logic [3:0]               rd_idx_i,
	output dbuc_code_t                    rd_data_o,
	output logic [16*12-1:0]              code_o
);

	dbuc_code_t hold_reg [16];
	dbuc_code_t rank_reg [16];
	dbuc_code_t hold_next [16];
	dbuc_code_t rd_reg;

	// Merge incoming byte lanes so a same-edge transfer sees the new code
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			hold_next[i] = hold_reg[i];
			if (wr_lo_i && (wr_idx_i == 4'(i)))
				hold_next[i][7:0] = wr_data_i[7:0];
			if (wr_hi_i && (wr_idx_i == 4'(i)))
				hold_next[i][11:8] = wr_data_i[11:8];
		end
	end

	// Both ranks and the registered read port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 16; i++) begin
				hold_reg[i] <= `DBUC_CODE_RST;
				rank_reg[i] <= `DBUC_CODE_RST;
			end
			rd_reg <= `DBUC_CODE_RST;
		end else begin
			for (int i = 0; i < 16; i++) begin
				hold_reg[i] <= hold_next[i];
				if (xfer_all_i || (xfer_one_i && (wr_idx_i == 4'(i))))
					rank_reg[i] <= hold_next[i];
			end
			rd_reg <= rank_reg[rd_idx_i];
		end
	end

	// Output rank straight from its flops
	always_comb begin
		for (int i = 0; i < 16; i++)
			code_o[i*12 +: 12] = rank_reg[i];
	end

	assign rd_data_o = rd_reg;

endmodule // dbuc_code_mem

// ---- src/dbuc_top.sv ----
// Analog output bank update controller: Wishbone slave, ranks, timer chain, interrupt
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "dbuc_consts.svh"

module dbuc_top
	import dbuc_pkg::*;
#(
	parameter int NUM_CH = `DBUC_NUM_CH
)
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Converter side
	output logic      [16*12-1:0]     dac_code_o,
	output logic                      ref_reduced_o,
	// Timer connector
	input  wire logic                 count_gate_i,
	input  wire logic                 event_in_i,
	output logic                      counter_update_pulse_out_o,
	// Interrupt
	output logic                      irq_o
);

	// ************************************************************************
	// Declarations
	// ************************************************************************
	dbuc_bus_e         bus_state_reg;
	dbuc_bus_e         bus_state_next;
	logic [31:0]       dat_reg;
	logic              ack_reg;
	logic              simul_reg;
	logic              ref_low_reg;
	logic              upd_en_reg;
	logic              int_en_reg;
	logic [1:0]        ctrl_reg;
	logic [`DBUC_IRQ_W-1:0] stat_reg;
	logic [`DBUC_IRQ_W-1:0] mask_reg;
	logic              irq_reg;
	logic              pulse_reg;
	logic              evt_prev_reg;
	logic [`DBUC_PRE_W-1:0] pre_reg;
	wire logic [7:0]   adr_word;
	wire logic [3:0]   word_idx;
	wire logic         act;
	wire logic         wr_act;
	wire logic         rd_act;
	wire logic         ch_hit;
	wire logic         cmd_hit;
	wire logic         cnt0_hit;
	wire logic         cnt1_hit;
	wire logic         cnt2_hit;
	wire logic         ctrl_hit;
	wire logic         stat_hit;
	wire logic         mask_hit;
	wire logic         state_hit;
	wire logic         cmd_rd;
	wire logic         cmd_simul;
	wire logic         cmd_indiv;
	wire logic         cmd_update;
	wire logic         cmd_int_on;
	wire logic         cmd_int_off;
	wire logic         cmd_upd_on;
	wire logic         cmd_upd_off;
	wire logic         cmd_ref_full;
	wire logic         cmd_ref_low;
	wire logic         mem_wr_lo;
	wire logic         mem_wr_hi;
	wire logic         xfer_one;
	wire logic         xfer_all;
	wire logic         sw_update;
	wire logic         timer_update;
	wire logic         simul_next;
	wire logic         ref_low_next;
	wire logic         upd_en_next;
	wire logic         int_en_next;
	wire logic [1:0]   ctrl_next;
	wire logic [`DBUC_IRQ_W-1:0] stat_set;
	wire logic [`DBUC_IRQ_W-1:0] stat_clr;
	wire logic [`DBUC_IRQ_W-1:0] stat_next;
	wire logic [`DBUC_IRQ_W-1:0] mask_next;
	wire logic         cnt_wr_ok;
	wire logic         osc_tick;
	wire logic         evt_edge;
	wire logic         cnt0_en;
	wire logic         cnt1_en;
	wire logic         cnt2_en;
	wire logic         cnt0_term;
	wire logic         cnt1_term;
	wire logic         tick;
	wire dbuc_count_t  cnt0_val;
	wire dbuc_count_t  cnt1_val;
	wire dbuc_count_t  cnt2_val;
	wire dbuc_code_t   mem_rd;
	wire logic [3:0]   state_bits;
	logic [31:0]       rd_word;

	// ************************************************************************
	// Bus sequencing
	// ************************************************************************
	// Idle sees a request, wait lets the code read port settle, ack answers
	always_comb begin
		unique case (bus_state_reg)
			DBUC_BUS_IDLE: bus_state_next = (wb_cyc_i && wb_stb_i) ? DBUC_BUS_WAIT
			                                                      : DBUC_BUS_IDLE;
			DBUC_BUS_WAIT: bus_state_next = DBUC_BUS_ACK;
			DBUC_BUS_ACK:  bus_state_next = DBUC_BUS_IDLE;
			default:       bus_state_next = DBUC_BUS_IDLE;
		endcase
	end

	// All side effects happen once, on the edge that raises ack
	assign act    = (bus_state_reg == DBUC_BUS_WAIT);
	assign wr_act = act & wb_we_i;
	assign rd_act = act & ~wb_we_i;

	// ************************************************************************
	// Address decode
	// ************************************************************************
	// Word-aligned decode; the low two address bits are ignored
	assign adr_word = {wb_adr_i[7:2], 2'b00};
	assign word_idx = wb_adr_i[5:2];
	assign ch_hit   = (wb_adr_i[7:6] == 2'b00) && ({28'h0000000, word_idx} < 32'(NUM_CH));
	assign cmd_hit  = (wb_adr_i[7:6] == 2'b01);
	assign cnt0_hit = (adr_word == `DBUC_ADR_CNT0);
	assign cnt1_hit = (adr_word == `DBUC_ADR_CNT1);
	assign cnt2_hit = (adr_word == `DBUC_ADR_CNT2);
	assign ctrl_hit = (adr_word == `DBUC_ADR_CTRL);
	assign stat_hit = (adr_word == `DBUC_ADR_STAT);
	assign mask_hit = (adr_word == `DBUC_ADR_MASK);
	assign state_hit = (adr_word == `DBUC_ADR_STATE);

	// ************************************************************************
	// Command reads
	// ************************************************************************
	// reads trigger commands
	assign cmd_rd       = rd_act & cmd_hit;
	assign cmd_simul    = cmd_rd & (word_idx == `DBUC_CMD_SIMUL);
	assign cmd_indiv    = cmd_rd & (word_idx == `DBUC_CMD_INDIV);
	assign cmd_update   = cmd_rd & (word_idx == `DBUC_CMD_UPDATE);
	assign cmd_int_on   = cmd_rd & (word_idx == `DBUC_CMD_INT_ON);
	assign cmd_int_off  = cmd_rd & (word_idx == `DBUC_CMD_INT_OFF);
	assign cmd_upd_on   = cmd_rd & (word_idx == `DBUC_CMD_UPD_ON);
	assign cmd_upd_off  = cmd_rd & (word_idx == `DBUC_CMD_UPD_OFF);
	assign cmd_ref_full = cmd_rd & (word_idx == `DBUC_CMD_REF_FULL);
	assign cmd_ref_low  = cmd_rd & (word_idx == `DBUC_CMD_REF_LOW);
	// Mode and enable flags; a write to the command window does nothing
	assign simul_next   = cmd_simul ? 1'b1 : (cmd_indiv ? 1'b0 : simul_reg);
	assign upd_en_next  = cmd_upd_on ? 1'b1 : (cmd_upd_off ? 1'b0 : upd_en_reg);
	assign int_en_next  = cmd_int_on ? 1'b1 : (cmd_int_off ? 1'b0 : int_en_reg);
	assign ref_low_next = cmd_ref_low ? 1'b1 : (cmd_ref_full ? 1'b0 : ref_low_reg);

	// ************************************************************************
	// Channel loading and updates
	// ************************************************************************
	// lane 0 low byte, lane 1 high nibble
	assign mem_wr_lo = wr_act & ch_hit & wb_sel_i[0];
	assign mem_wr_hi = wr_act & ch_hit & wb_sel_i[1];
	assign xfer_one  = mem_wr_hi & ~simul_reg;
	assign sw_update    = cmd_update & simul_reg;
	assign timer_update = tick & upd_en_reg & simul_reg;
	assign xfer_all     = sw_update | timer_update;

	// channels beyond the count stay unmapped
	dbuc_code_mem u_code_mem (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wr_lo_i    (mem_wr_lo),
		.wr_hi_i    (mem_wr_hi),
		.wr_idx_i   (word_idx),
		.wr_data_i  (wb_dat_i[11:0]),
		.xfer_one_i (xfer_one),
		.xfer_all_i (xfer_all),
		.rd_idx_i   (word_idx),
		.rd_data_o  (mem_rd),
		.code_o     (dac_code_o)
	);

	// ************************************************************************
	// Timer chain
	// ************************************************************************
	// 1 MHz base from the card clock; the gate freezes it in place
	assign osc_tick = (pre_reg == `DBUC_PRE_W'(`DBUC_OSC_DIV - 1)) & count_gate_i;
	// Event input is taken as synchronous, so a plain edge detect suffices
	assign evt_edge = event_in_i & ~evt_prev_reg;
	assign cnt0_en = evt_edge & ctrl_reg[`DBUC_CTRL_EVT_EN];
	assign cnt1_en = osc_tick & ctrl_reg[`DBUC_CTRL_CASC_EN];
	// counter 2 counts counter 1 wraps
	assign cnt2_en = cnt1_term & ctrl_reg[`DBUC_CTRL_CASC_EN];
	assign cnt_wr_ok = wr_act & (wb_sel_i[1:0] != 2'b00);
	dbuc_down_counter u_cnt0 (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (cnt_wr_ok & cnt0_hit),
		.load_val_i (wb_dat_i[15:0]),
		.count_en_i (cnt0_en),
		.count_o    (cnt0_val),
		.term_o     (cnt0_term)
	);
	dbuc_down_counter u_cnt1 (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (cnt_wr_ok & cnt1_hit),
		.load_val_i (wb_dat_i[15:0]),
		.count_en_i (cnt1_en),
		.count_o    (cnt1_val),
		.term_o     (cnt1_term)
	);
	dbuc_down_counter u_cnt2 (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (cnt_wr_ok & cnt2_hit),
		.load_val_i (wb_dat_i[15:0]),
		.count_en_i (cnt2_en),
		.count_o    (cnt2_val),
		.term_o     (tick)
	);

	// ************************************************************************
	// Control, status and mask
	// ************************************************************************
	// Counter enables, written from software
	assign ctrl_next = (wr_act & ctrl_hit & wb_sel_i[0]) ? wb_dat_i[1:0] : ctrl_reg;
	assign mask_next = (wr_act & mask_hit & wb_sel_i[0]) ? wb_dat_i[`DBUC_IRQ_W-1:0]
	                                                     : mask_reg;
	assign stat_set[`DBUC_IRQ_TICK] = tick & int_en_reg;
	assign stat_set[`DBUC_IRQ_EVT]  = cnt0_term;
	// Read clears; a set in the same edge survives so no event is lost
	assign stat_clr  = {`DBUC_IRQ_W{rd_act & stat_hit}};
	assign stat_next = (stat_reg & ~stat_clr) | stat_set;

	// ************************************************************************
	// Read data
	// ************************************************************************
	assign state_bits = {int_en_reg, upd_en_reg, ref_low_reg, simul_reg};

	// Unmapped words outside the command window and channels beyond the bank read as zero; every command word reads the state bits
	always_comb begin
		rd_word = 32'h00000000;
		if (ch_hit)
			rd_word = {20'h00000, mem_rd};
		else if (cmd_hit || state_hit)
			rd_word = {28'h0000000, state_bits};
		else if (cnt0_hit)
			rd_word = {16'h0000, cnt0_val};
		else if (cnt1_hit)
			rd_word = {16'h0000, cnt1_val};
		else if (cnt2_hit)
			rd_word = {16'h0000, cnt2_val};
		else if (ctrl_hit)
			rd_word = {30'h00000000, ctrl_reg};
		else if (stat_hit)
			rd_word = {30'h00000000, stat_reg};
		else if (mask_hit)
			rd_word = {30'h00000000, mask_reg};
	end

	// ************************************************************************
	// Registers
	// ************************************************************************
	// Bus slave flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_reg <= DBUC_BUS_IDLE;
			ack_reg       <= 1'b0;
			dat_reg       <= 32'h00000000;
		end else begin
			bus_state_reg <= bus_state_next;
			ack_reg       <= act;
			dat_reg       <= rd_act ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			simul_reg   <= 1'b0;
			ref_low_reg <= 1'b1;
			upd_en_reg  <= 1'b0;
			int_en_reg  <= 1'b0;
		end else begin
			simul_reg   <= simul_next;
			ref_low_reg <= ref_low_next;
			upd_en_reg  <= upd_en_next;
			int_en_reg  <= int_en_next;
		end
	end

	// Timer, interrupt and pulse flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg     <= `DBUC_CTRL_RST;
			mask_reg     <= `DBUC_MASK_RST;
			stat_reg     <= '0;
			irq_reg      <= 1'b0;
			pulse_reg    <= 1'b0;
			evt_prev_reg <= 1'b0;
			pre_reg      <= '0;
		end else begin
			ctrl_reg     <= ctrl_next;
			mask_reg     <= mask_next;
			stat_reg     <= stat_next;
			irq_reg      <= |(stat_reg & mask_reg);
			pulse_reg    <= tick;
			evt_prev_reg <= event_in_i;
			if (count_gate_i)
				pre_reg <= osc_tick ? '0 : pre_reg + `DBUC_PRE_W'(1);
		end
	end

	// ************************************************************************
	// Outputs
	// ************************************************************************
	assign wb_dat_o                   = dat_reg;
	assign wb_ack_o                   = ack_reg;
	assign ref_reduced_o              = ref_low_reg;
	assign irq_o                      = irq_reg;
	assign counter_update_pulse_out_o = pulse_reg;

endmodule // dbuc_top

// ---- testbench/dbuc_properties.sv ----
// Concurrent checks on the update controller ports
`timescale 1ns/1ps

module dbuc_checker (
	// Clock and reset
	input wire logic          clk_i,
	input wire logic          rst_i,
	// Bus
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [3:0]    wb_sel_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	// Outputs
	input wire logic [191:0]  dac_code_o,
	input wire logic          ref_reduced_o,
	input wire logic          counter_update_pulse_out_o,
	input wire logic          irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Handshake, data and output causes
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_delay: assert property ($rose(wb_stb_i) |-> ##2 wb_ack_o)
		else $error("ack latency wrong");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_ref_poweron: assert property ($fell(rst_i) |-> ref_reduced_o && dac_code_o == '0)
		else $error("reset state wrong");
	// Reset moves the flag as well; the edge after its release still sees that change
	a_ref_cmd: assert property ($changed(ref_reduced_o) && !$past(rst_i)
		|-> wb_ack_o && !wb_we_i)
		else $error("reference flag moved without command");
	a_pulse_one: assert property (counter_update_pulse_out_o |=> !counter_update_pulse_out_o)
		else $error("update pulse too long");
	a_code_cause: assert property ($changed(dac_code_o) && !wb_ack_o && !$past(rst_i)
		|-> ##[0:1] counter_update_pulse_out_o)
		else $error("outputs moved without update");
	a_low_hold: assert property (wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'b01
		|-> $stable(dac_code_o))
		else $error("low byte moved output");

	// Main scenarios
	c_write: cover property (wb_ack_o && wb_we_i);
	c_ref_full: cover property ($fell(ref_reduced_o));
	c_tick: cover property (counter_update_pulse_out_o);
	c_irq: cover property (irq_o);
endmodule // dbuc_checker

bind dbuc_top dbuc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.dac_code_o(dac_code_o), .ref_reduced_o(ref_reduced_o),
	.counter_update_pulse_out_o(counter_update_pulse_out_o), .irq_o(irq_o));

// ---- testbench/dbuc_host_model.sv ----
// Host processor model: classic single-cycle bus master
`timescale 1ns/1ps

module dbuc_host_model (
	// Clock and answer
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	// Request
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [7:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat, output logic [31:0] q, output bit ok);
		ok = 1'b0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, we, adr, sel, dat};
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge clk_i);
			ok = ack_i;
		end
		q = dat_i;
		{cyc_o, stb_o} <= 2'b00;
		// Released data shows garbage, not the last value
		dat_o <= ~dat;
	endtask
endmodule // dbuc_host_model

// ---- testbench/dac_bank_update_control_bench.sv ----
// Self-checking bench of the update controller
`timescale 1ns/1ps

module dac_bank_update_control_bench;
	import dbuc_pkg::*;
	logic clk_i = 0, rst_i = 1, count_gate_i = 1, event_in_i = 0;
	logic cyc, stb, we, ack, pulse, irq, ref_low;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [191:0] dac, old;
	dbuc_code_t exp_code [16];
	int fail_count = 0, comparisons = 0, seed = 32'h8621;

	initial forever #12.5 clk_i = ~clk_i;

	dbuc_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
	dbuc_top #(.NUM_CH(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .dac_code_o(dac), .ref_reduced_o(ref_low), .count_gate_i(count_gate_i),
		.event_in_i(event_in_i), .counter_update_pulse_out_o(pulse), .irq_o(irq));

	// Verdict and end of run
	task automatic results();
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [191:0] got, input logic [191:0] want);
		comparisons++;
		if (got !== want) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask

	function automatic logic [191:0] pk();
		for (int i = 0; i < 16; i++) pk[i*12 +: 12] = exp_code[i];
	endfunction

	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		bit ok;
		host.xfer(w, a, s, d, q, ok);
		if (!ok) begin
			$display("CHECK FAILED at %0t: no bus answer", $time);
			fail_count++;
			results();
		end
	endtask

	task automatic cmd(input int n);
		bus(1'b0, 8'h40 + 8'(4 * n), 4'hf, 32'h0);
	endtask

	task automatic wait_pulse();
		int n;
		for (n = 0; n < 2000 && pulse !== 1'b1; n++) @(posedge clk_i);
		if (n == 2000) begin
			$display("CHECK FAILED at %0t: no update pulse", $time);
			fail_count++;
			results();
		end
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < 16; i++) exp_code[i] = 12'h000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(ref_low, 1);
		bus(0, 8'h98, 4'hf, 0); chk(q, 32'h2);
		for (int i = 0; i < 16; i++) begin
			// codes kept within twelve bits
			// Output rank as it stood before this channel's bytes
			old = pk();
			exp_code[i] = 12'($random(seed));
			bus(1, 8'(4 * i), 4'h1, {20'h0, exp_code[i]}); chk(dac, old);
			bus(1, 8'(4 * i), 4'h2, {20'h0, exp_code[i]}); chk(dac, pk());
			bus(0, 8'(4 * i), 4'hf, 0); chk(q, {20'h0, exp_code[i]});
		end
		bus(0, 8'hfc, 4'hf, 0); chk(q, 0);
		cmd(0); old = pk();
		bus(1, 8'h0c, 4'h3, 32'hfff); chk(dac, old);
		exp_code[3] = 12'hfff;
		cmd(2); chk(dac, pk());
		cmd(1); bus(0, 8'h98, 4'hf, 0); chk(q[0], 0);
		cmd(7); chk(ref_low, 0);
		cmd(8); chk(ref_low, 1);
		cmd(7);
		cmd(4); cmd(6); cmd(0); old = pk();
		for (int i = 0; i < 16; i++) begin
			exp_code[i] = 12'($random(seed));
			bus(1, 8'(4 * i), 4'h3, {20'h0, exp_code[i]});
		end
		chk(dac, old);
		bus(1, 8'h84, 4'h3, 32'h2); bus(1, 8'h88, 4'h3, 32'h3);
		bus(1, 8'h94, 4'h1, 32'h1); bus(1, 8'h8c, 4'h1, 32'h2);
		cmd(5); cmd(3);
		wait_pulse(); chk(dac, pk());
		repeat (2) @(posedge clk_i); chk(irq, 1);
		bus(0, 8'h90, 4'hf, 0); chk(q[0], 1);
		repeat (2) @(posedge clk_i); chk(irq, 0);
		bus(1, 8'h94, 4'h1, 32'h0);
		wait_pulse(); repeat (2) @(posedge clk_i); chk(irq, 0);
		// Gate low must freeze the cascade
		count_gate_i <= 1'b0; old = 0;
		repeat (600) begin
			@(posedge clk_i);
			old[0] = old[0] | pulse;
		end
		chk(old[0], 0);
		count_gate_i <= 1'b1; wait_pulse(); chk(pulse, 1);
		bus(1, 8'h80, 4'h3, 32'h2); bus(1, 8'h8c, 4'h1, 32'h3);
		repeat (3) begin
			event_in_i <= 1'b1; repeat (3) @(posedge clk_i);
			event_in_i <= 1'b0; repeat (3) @(posedge clk_i);
		end
		bus(0, 8'h90, 4'hf, 0); chk(q[1], 1);
		// Reload of two after three events leaves one
		bus(0, 8'h80, 4'hf, 0); chk(q, 32'h1);
		rst_i <= 1'b1; repeat (2) @(posedge clk_i);
		rst_i <= 1'b0; @(posedge clk_i);
		chk({ref_low, dac}, {1'b1, 192'h0});
		results();
	end
endmodule // dac_bank_update_control_bench
